// *** hw/dpr_pkg.sv ***
// constants for the dynamic phase alignment receiver
package dpr_pkg;
  localparam int PHASES = 8;
  localparam int SEL_W = 3;
  localparam int UI_PS = 1000;
  localparam int RES_PS = UI_PS / PHASES;
  localparam int RATE_ALIGN_MBPS = 1000;
  localparam int RATE_BYPASS_MBPS = 840;
  localparam int DESER_J = 10;
  localparam int SYNC_DEPTH = 4;
  localparam int LOCK_RUN = 16;
  localparam int CORE_PERIOD_PS = 5000;
  localparam logic [SEL_W-1:0] PHASE_RST = 3'h0;
  localparam logic [SEL_W-1:0] CENTER_OFS = 3'h5;
  localparam logic [SEL_W-1:0] HALF_TURN = 3'h4;
endpackage : dpr_pkg

// *** hw/dpr_word_if.sv ***
// word carrier between deserializer and synchronizer FIFO
`timescale 1ns/1ps
interface dpr_word_if #(parameter int W = 10);
  logic [W-1:0] word;
  logic valid;
  logic ready;
  modport src (output word, output valid, input ready);
  modport snk (input word, input valid, output ready);
endinterface : dpr_word_if

// *** hw/dpr_deser.sv ***
// serial to parallel converter on the link clock
`timescale 1ns/1ps
module dpr_deser import dpr_pkg::*; #(
  parameter int J = DESER_J
) (
  // link side
  input wire logic lnk_clk,
  input wire logic lnk_rst,
  input wire logic bit_in,
  // parallel words out
  dpr_word_if.src out
);
  logic [J-1:0] shift_r;
  logic [J-1:0] shift_nxt;
  logic [$clog2(J)-1:0] cnt_r;
  logic [$clog2(J)-1:0] cnt_nxt;
  logic last_bit;
  logic [J-1:0] word_r;
  logic valid_r;

  generate
    if (J != 8 && J != 10) begin : g_bad_j
      $error("deserialization factor must be 8 or 10");
    end
  endgenerate

  assign shift_nxt = {shift_r[J-2:0], bit_in};
  assign last_bit = (cnt_r == ($clog2(J))'(J - 1));
  assign cnt_nxt = last_bit ? '0 : cnt_r + 1'b1;

  always_ff @(posedge lnk_clk or posedge lnk_rst) begin
    if (lnk_rst) begin
      shift_r <= '0;
      cnt_r <= '0;
      word_r <= '0;
      valid_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      cnt_r <= cnt_nxt;
      valid_r <= last_bit;
      if (last_bit) begin
        word_r <= shift_nxt;
      end
    end
  end

  assign out.word = word_r;
  assign out.valid = valid_r;
endmodule : dpr_deser

// *** hw/dpr_sync_fifo.sv ***
// dual-clock phase synchronizer fifo with gray pointers
`timescale 1ns/1ps
module dpr_sync_fifo import dpr_pkg::*; #(
  parameter int WIDTH = DESER_J,
  parameter int DEPTH = SYNC_DEPTH
) (
  // parallel side
  input wire logic wr_clk,
  input wire logic wr_rst,
  dpr_word_if.snk wr,
  // global side
  input wire logic rd_clk,
  input wire logic rd_rst,
  output logic [WIDTH-1:0] rd_word,
  output logic rd_valid,
  input wire logic rd_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;

  generate
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 4");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wbin_r, wgray_r, rbin_r, rgray_r;
  logic [PW-1:0] wbin_nxt, rbin_nxt;
  logic [PW-1:0] rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
  logic full, empty, do_wr, do_rd;

  // gray pointers cross between the domains
  assign full = (wgray_r == {~rg_s2_r[PW-1:PW-2], rg_s2_r[PW-3:0]});
  assign empty = (rgray_r == wg_s2_r);
  assign do_wr = wr.valid && !full;
  assign do_rd = rd_ready && !empty;
  assign wbin_nxt = wbin_r + PW'(do_wr);
  assign rbin_nxt = rbin_r + PW'(do_rd);
  assign wr.ready = !full;
  assign rd_valid = !empty;
  assign rd_word = mem[rbin_r[AW-1:0]];

  always_ff @(posedge wr_clk) begin
    if (do_wr) begin
      mem[wbin_r[AW-1:0]] <= wr.word;
    end
  end

  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      wbin_r <= '0;
      wgray_r <= '0;
      rg_s1_r <= '0;
      rg_s2_r <= '0;
    end else begin
      wbin_r <= wbin_nxt;
      wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
    end
  end

  always_ff @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      rbin_r <= '0;
      rgray_r <= '0;
      wg_s1_r <= '0;
      wg_s2_r <= '0;
    end else begin
      rbin_r <= rbin_nxt;
      rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
    end
  end
endmodule : dpr_sync_fifo

// *** hw/dpr_receiver.sv ***
// one receive channel: phase select, deserializer, global-clock synchronizer
`timescale 1ns/1ps
module dpr_receiver import dpr_pkg::*; #(
  parameter int J = DESER_J,
  parameter int DEPTH = SYNC_DEPTH,
  parameter int LOCK_N = LOCK_RUN
) (
  // shared global clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // link side: multiplied bit clock and eight phase samples
  input wire logic lnk_clk,
  input wire logic [PHASES-1:0] rx_samples,
  // mode pin
  input wire logic bypass_align,
  // parallel words on the global clock
  output logic [J-1:0] rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  // status
  output logic locked,
  output logic [SEL_W-1:0] sel_phase,
  output logic overflow
);
  generate
    if (LOCK_N < 1 || LOCK_N > 255) begin : g_bad_lock
      $error("lock run length out of range");
    end
  endgenerate

  // link-domain reset, asserted at once, released on lnk_clk
  logic lrst_s1_r, lnk_rst;
  always_ff @(posedge lnk_clk or posedge reset) begin
    if (reset) begin
      lrst_s1_r <= 1'b1;
      lnk_rst <= 1'b1;
    end else begin
      lrst_s1_r <= 1'b0;
      lnk_rst <= lrst_s1_r;
    end
  end

  // pin inputs into the link domain
  logic [PHASES-1:0] smp_s1_r, smp_r;
  logic byp_s1_r, byp_r;
  always_ff @(posedge lnk_clk or posedge lnk_rst) begin
    if (lnk_rst) begin
      smp_s1_r <= '0;
      smp_r <= '0;
      byp_s1_r <= 1'b0;
      byp_r <= 1'b0;
    end else begin
      smp_s1_r <= rx_samples;
      smp_r <= smp_s1_r;
      byp_s1_r <= bypass_align;
      byp_r <= byp_s1_r;
    end
  end

  // edge search across the eight phase samples
  logic [PHASES-2:0] edge_vec;
  genvar gi;
  generate
    for (gi = 0; gi < PHASES - 1; gi++) begin : g_edge
      assign edge_vec[gi] = smp_r[gi] ^ smp_r[gi+1];
    end
  endgenerate

  function automatic logic [SEL_W-1:0] first_edge(
    input logic [PHASES-2:0] v
  );
    logic [SEL_W-1:0] idx;
    idx = '0;
    for (int i = PHASES - 2; i >= 0; i--) begin
      if (v[i]) begin
        idx = SEL_W'(i);
      end
    end
    return idx;
  endfunction : first_edge

  logic one_edge;
  logic [SEL_W-1:0] edge_idx;
  logic [SEL_W-1:0] target;
  logic [SEL_W-1:0] goal;
  logic [SEL_W-1:0] diff;
  logic [SEL_W-1:0] sel_lnk_r, sel_lnk_nxt;
  logic may_step, step_up, step_dn;
  assign one_edge = (edge_vec != '0) &&
                    ((edge_vec & (edge_vec - 1'b1)) == '0);
  assign edge_idx = first_edge(edge_vec);
  assign target = edge_idx + CENTER_OFS;
  // bypass slews back to phase zero, never jumps
  assign goal = byp_r ? PHASE_RST : target;
  assign diff = goal - sel_lnk_r;
  assign may_step = byp_r || one_edge;
  assign step_up = may_step && (diff != '0) && (diff < HALF_TURN);
  assign step_dn = may_step && (diff >= HALF_TURN);

  // phase selection, one step of an eighth bit per clock
  logic [7:0] run_r, run_nxt;
  logic lock_lnk_r, lock_lnk_nxt;
  logic retimed_bit;
  assign sel_lnk_nxt = step_up ? sel_lnk_r + 1'b1 :
                       step_dn ? sel_lnk_r - 1'b1 : sel_lnk_r;
  assign run_nxt = (byp_r || step_up || step_dn) ? 8'h00 :
                   (run_r == 8'(LOCK_N)) ? run_r : run_r + 8'h01;
  assign lock_lnk_nxt = !byp_r && (run_nxt == 8'(LOCK_N));
  assign retimed_bit = smp_r[sel_lnk_r];

  always_ff @(posedge lnk_clk or posedge lnk_rst) begin
    if (lnk_rst) begin
      sel_lnk_r <= PHASE_RST;
      run_r <= 8'h00;
      lock_lnk_r <= 1'b0;
    end else begin
      sel_lnk_r <= sel_lnk_nxt;
      run_r <= run_nxt;
      lock_lnk_r <= lock_lnk_nxt;
    end
  end

  // deserializer on the retimed bit
  dpr_word_if #(.W(J)) wbus ();
  dpr_deser #(.J(J)) u_deser (
    .lnk_clk(lnk_clk),
    .lnk_rst(lnk_rst),
    .bit_in(retimed_bit),
    .out(wbus.src)
  );

  // word dropped when the synchronizer cannot take it
  logic ovf_lnk_r;
  always_ff @(posedge lnk_clk or posedge lnk_rst) begin
    if (lnk_rst) begin
      ovf_lnk_r <= 1'b0;
    end else if (wbus.valid && !wbus.ready) begin
      ovf_lnk_r <= 1'b1;
    end
  end

  // synchronizer onto the global clock
  logic [J-1:0] ff_word;
  logic ff_valid, ff_take;
  dpr_sync_fifo #(.WIDTH(J), .DEPTH(DEPTH)) u_sync (
    .wr_clk(lnk_clk),
    .wr_rst(lnk_rst),
    .wr(wbus.snk),
    .rd_clk(core_clk),
    .rd_rst(reset),
    .rd_word(ff_word),
    .rd_valid(ff_valid),
    .rd_ready(ff_take)
  );

  // status crossings: levels by two flops, phase as gray code
  logic [SEL_W-1:0] sel_gray_r;
  logic [SEL_W-1:0] sg_s1_r, sg_s2_r;
  logic lk_s1_r, lk_s2_r, ov_s1_r, ov_s2_r;
  always_ff @(posedge lnk_clk or posedge lnk_rst) begin
    if (lnk_rst) begin
      sel_gray_r <= '0;
    end else begin
      sel_gray_r <= sel_lnk_r ^ (sel_lnk_r >> 1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sg_s1_r <= '0;
      sg_s2_r <= '0;
      lk_s1_r <= 1'b0;
      lk_s2_r <= 1'b0;
      ov_s1_r <= 1'b0;
      ov_s2_r <= 1'b0;
    end else begin
      sg_s1_r <= sel_gray_r;
      sg_s2_r <= sg_s1_r;
      lk_s1_r <= lock_lnk_r;
      lk_s2_r <= lk_s1_r;
      ov_s1_r <= ovf_lnk_r;
      ov_s2_r <= ov_s1_r;
    end
  end

  logic [SEL_W-1:0] sel_bin;
  generate
    for (gi = 0; gi < SEL_W; gi++) begin : g_ungray
      assign sel_bin[gi] = ^(sg_s2_r >> gi);
    end
  endgenerate

  // registered output stage on the global clock
  logic [J-1:0] word_r;
  logic valid_r, locked_r, ovf_r;
  logic [SEL_W-1:0] sel_r;
  assign ff_take = !valid_r || rx_ready;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      word_r <= '0;
      valid_r <= 1'b0;
      locked_r <= 1'b0;
      sel_r <= PHASE_RST;
      ovf_r <= 1'b0;
    end else begin
      if (ff_take) begin
        valid_r <= ff_valid;
        word_r <= ff_valid ? ff_word : word_r;
      end
      locked_r <= lk_s2_r;
      sel_r <= sel_bin;
      ovf_r <= ov_s2_r;
    end
  end

  assign rx_word = word_r;
  assign rx_valid = valid_r;
  assign locked = locked_r;
  assign sel_phase = sel_r;
  assign overflow = ovf_r;
endmodule : dpr_receiver

// *** testbench/dpr_tx_model.sv ***
// far-end transmitter model driving eight phase samples
`timescale 1ns/1ps
module dpr_tx_model import dpr_pkg::*; (
  // link clock and pattern control
  input wire logic lnk_clk,
  input wire logic [1:0] pat_sel,
  input wire logic [SEL_W-1:0] edge_pos,
  // sampled line
  output logic [PHASES-1:0] rx_samples
);
  logic [4:0] cnt_r = 5'h00;
  logic bit_r = 1'b0;
  logic nxt;
  always_comb begin
    case (pat_sel)
      2'h0: nxt = !cnt_r[0];
      2'h1: nxt = cnt_r[2];
      2'h2: nxt = !cnt_r[2] && (cnt_r[1:0] == 2'h0 || cnt_r[1:0] == 2'h3);
      default: nxt = cnt_r >= 5'h0A;
    endcase
  end
  // samples up to edge_pos still see the previous bit
  always @(posedge lnk_clk) begin
    bit_r <= nxt;
    cnt_r <= (pat_sel == 2'h3 && cnt_r == 5'h13) ? 5'h00 : cnt_r + 5'h01;
    for (int i = 0; i < PHASES; i++)
      rx_samples[i] <= (SEL_W'(i) <= edge_pos) ? bit_r : nxt;
  end
endmodule : dpr_tx_model

// *** testbench/dpr_receiver_checker.sv ***
// port assertions for the receiver channel
`timescale 1ns/1ps
module dpr_receiver_checker import dpr_pkg::*; #(
  parameter int J = DESER_J,
  parameter int LOCK_N = LOCK_RUN
) (
  // clocks and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic lnk_clk,
  // inputs
  input wire logic [PHASES-1:0] rx_samples,
  input wire logic bypass_align,
  input wire logic rx_ready,
  // outputs
  input wire logic [J-1:0] rx_word,
  input wire logic rx_valid,
  input wire logic locked,
  input wire logic [SEL_W-1:0] sel_phase,
  input wire logic overflow
);
  logic [5:0] byp_r;
  logic [7:0] stab_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) byp_r <= 6'h00;
    else if (!bypass_align) byp_r <= 6'h00;
    else if (byp_r != 6'h3F) byp_r <= byp_r + 6'h01;
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) stab_r <= 8'h00;
    else if ($changed(sel_phase)) stab_r <= 8'h00;
    else if (stab_r != 8'hFF) stab_r <= stab_r + 8'h01;
  end
  sequence s_stall;
    rx_valid && !rx_ready;
  endsequence
  sequence s_step;
    $changed(sel_phase);
  endsequence
  property p_hold;
    s_stall |=> rx_valid && $stable(rx_word);
  endproperty
  a_hold: assert property (p_hold)
    else $error("word moved while stalled");
  property p_step;
    s_step |-> (3'(sel_phase - $past(sel_phase)) inside {3'h1, 3'h7});
  endproperty
  a_step: assert property (p_step)
    else $error("phase jumped more than one step");
  property p_gap;
    s_step |=> $stable(sel_phase)[*3];
  endproperty
  a_gap: assert property (p_gap)
    else $error("phase stepped faster than link rate");
  property p_unlock;
    s_step |-> ##[0:4] !locked;
  endproperty
  a_unlock: assert property (p_unlock)
    else $error("lock kept across phase step");
  property p_lockrun;
    $rose(locked) |-> stab_r >= 8'((LOCK_N - 1) * 5);
  endproperty
  a_lockrun: assert property (p_lockrun)
    else $error("lock without stable phase run");
  property p_bypass;
    byp_r == 6'h3F |-> sel_phase == PHASE_RST && !locked;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass not holding phase zero");
  property p_sticky;
    overflow |=> overflow;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("overflow flag cleared");
  property p_rstout;
    $fell(reset) |-> !rx_valid && !locked && !overflow && sel_phase == 3'h0;
  endproperty
  a_rstout: assert property (p_rstout)
    else $error("outputs not clear after reset");
endmodule : dpr_receiver_checker

bind dpr_receiver dpr_receiver_checker #(.J(J), .LOCK_N(LOCK_N)) u_chk (
  .core_clk(core_clk), .reset(reset), .lnk_clk(lnk_clk),
  .rx_samples(rx_samples), .bypass_align(bypass_align),
  .rx_ready(rx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
  .locked(locked), .sel_phase(sel_phase), .overflow(overflow));

// *** testbench/tb_dpr_receiver.sv ***
// self-checking bench for the receiver channel
`timescale 1ns/1ps
module tb_dpr_receiver import dpr_pkg::*; ();
  localparam int J = 10;
  logic core_clk = 1'b0;
  logic lnk_clk = 1'b0;
  logic reset = 1'b1;
  logic bypass_align = 1'b0;
  logic rx_ready = 1'b1;
  logic [1:0] pat_sel = 2'h0;
  logic [SEL_W-1:0] edge_pos = 3'h2;
  logic [PHASES-1:0] rx_samples;
  logic [J-1:0] rx_word;
  logic rx_valid;
  logic locked;
  logic overflow;
  logic [SEL_W-1:0] sel_phase;
  int mismatches = 0;
  int checked = 0;
  initial forever #2.5 core_clk = ~core_clk;
  initial begin
    #7;
    forever #16 lnk_clk = ~lnk_clk;
  end
  dpr_tx_model u_dpr_tx_model (.lnk_clk(lnk_clk), .pat_sel(pat_sel),
    .edge_pos(edge_pos), .rx_samples(rx_samples));
  dpr_receiver #(.J(J), .LOCK_N(4)) u_dpr_receiver (.core_clk(core_clk),
    .reset(reset), .lnk_clk(lnk_clk), .rx_samples(rx_samples),
    .bypass_align(bypass_align), .rx_word(rx_word), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .locked(locked), .sel_phase(sel_phase),
    .overflow(overflow));
  task automatic chk(input string n, input logic [J-1:0] s, e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  task automatic chk_lock(input logic [SEL_W-1:0] tgt);
    chk("sel", J'(sel_phase), J'(tgt));
    chk("lock", J'(locked), 10'h001);
  endtask : chk_lock
  task automatic t_data;
    int w;
    w = 0;
    cyc(800);
    repeat (400) begin
      @(negedge core_clk);
      if (rx_valid === 1'b1) begin
        w++;
        chk("word", J'(rx_word == 10'h2AA || rx_word == 10'h155), 10'h1);
      end
    end
    chk("rate", J'(w >= 6 && w <= 7), 10'h001);
    chk_lock(3'h7);
  endtask : t_data
  task automatic t_drift;
    edge_pos <= 3'h6;
    cyc(600);
    chk_lock(3'h3);
  endtask : t_drift
  task automatic t_stall;
    chk("ovf", J'(overflow), 10'h000);
    rx_ready <= 1'b0;
    cyc(800);
    chk("ovf", J'(overflow), 10'h001);
    chk("vld", J'(rx_valid), 10'h001);
    rx_ready <= 1'b1;
    cyc(20);
    chk("ovf", J'(overflow), 10'h001);
  endtask : t_stall
  task automatic t_train;
    for (int m = 0; m < 4; m++) begin
      pat_sel <= 2'(m);
      edge_pos <= 3'(2 * m);
      cyc(1400);
      chk_lock(3'(2 * m + 5));
    end
  endtask : t_train
  task automatic t_bypass;
    bypass_align <= 1'b1;
    cyc(200);
    chk("byp", J'({sel_phase, locked}), 10'h000);
    bypass_align <= 1'b0;
    reset <= 1'b1;
    cyc(40);
    chk("rst", J'({rx_valid, overflow, locked}), 10'h000);
    reset <= 1'b0;
    cyc(700);
    chk_lock(3'(edge_pos + 3'h5));
  endtask : t_bypass
  initial begin
    repeat (4) @(posedge lnk_clk);
    @(posedge core_clk);
    reset <= 1'b0;
    t_data();
    t_drift();
    t_stall();
    t_train();
    t_bypass();
    end_sim();
  end
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
endmodule : tb_dpr_receiver
